// ### verilog/sxd_pkg.sv
// Shared constants and types of the extended serial command decoder.
// Assumes a single 200 MHz system clock and a mode-0 serial master.
`default_nettype none

package sxd_pkg;

    // Command codes
    localparam logic [7:0] CMD_UNLOCK = 8'h50;
    localparam logic [7:0] CMD_RX_WIDTH = 8'h60;
    localparam logic [7:0] CMD_NOACK_TX = 8'hB0;
    localparam logic [7:0] CMD_NOP = 8'hFF;
    localparam logic [4:0] CMD_ACK_TOP = 5'h15;
    localparam logic [1:0] CMD_REG_TOP = 2'h0;

    // Unlock data values
    localparam logic [7:0] UNLOCK_FEATURES = 8'h73;
    localparam logic [7:0] UNLOCK_BANK = 8'h53;

    // Limits
    localparam logic [2:0] PIPE_MAX = 3'h5;
    localparam logic [1:0] ACK_PENDING_MAX = 2'h3;
    localparam logic [5:0] PAYLOAD_MAX = 6'h20;
    localparam logic [4:0] BANK1_MSB_LAST_REG = 5'h08;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Payload buffer shape
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    // Reset values
    localparam logic SELECT_IDLE = 1'b1;
    localparam logic FEATURES_RESET = 1'b0;
    localparam logic BANK_RESET = 1'b0;

    // Frame sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CMD = 3'b010,
        ST_DATA = 3'b100
    } sxd_state_e;

endpackage

`default_nettype wire

// ### verilog/sxd_fifo.sv
// Payload byte FIFO with a registered read stage.
// Assumes depth is a power of two; one clock, asynchronous low reset.
`default_nettype none

module sxd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [WIDTH-1:0] od;
    } sxd_fifo_s;

    sxd_fifo_s s;
    sxd_fifo_s next_s;

    logic full;

    // Store and output register together hold DEPTH words
    assign full = (s.cnt + (AW + 1)'(s.ov)) == FULL;
    assign in_ready = !full;
    assign out_valid = s.ov;
    assign out_data = s.od;

    // Push into store, refill output register when it frees
    always_comb
    begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        next_s = s;
        push = in_valid && !full;
        pop = (s.cnt != '0) && (!s.ov || out_ready);
        if (push)
        begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = s.wp + 1'b1;
        end
        if (pop)
        begin
            next_s.od = s.mem[s.rp];
            next_s.rp = s.rp + 1'b1;
            next_s.ov = 1'b1;
        end
        else if (out_ready)
        begin
            next_s.ov = 1'b0;
        end
        next_s.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

`default_nettype wire

// ### verilog/sxd_decoder.sv
// Extended serial command decoder: unlock, bank toggle, width read,
// acknowledge and no-acknowledge payload writes, no-op status read.
// Assumes a mode-0 master whose pins are sampled by the 200 MHz mclk.
//
// How it works
// - unlock with 0x73 activates optional features
// - repeating that unlock deactivates them again
// - unlock only honoured in power-down or standby
// - reset inactive; inactive writes ignored, reads zero
// - unlock with 0x53 toggles bank, shown bit7
// - width command returns head payload byte count
// - ack write pipe index valid 0 to 5
// - three ack payloads pending, same pipe FIFO
// - ack payload 1 to 32 bytes from byte 0
// - no-ack write queues payload, no auto acknowledge
// - no-op changes nothing, status shifted out
// - bank1 regs 0-8 MSB byte first, else LSB
// - select fall starts command, status shifts out
// - command byte shifted most significant bit first
`default_nettype none

module sxd_decoder (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic select_n_pin,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    input wire logic [7:0] status_in,
    input wire logic [5:0] rx_width,
    input wire logic idle_power_state,
    input wire logic rx_mode,
    input wire logic ack_sent,
    output logic features_active,
    output logic bank_indicator_bit,
    output logic msb_byte_first,
    output logic pkt_done,
    output logic pkt_no_auto_acknowledge,
    output logic [2:0] ack_pipe_index,
    output logic [5:0] pkt_len,
    output logic [1:0] ack_pending,
    output logic overflow,
    output logic pl_valid,
    output logic [7:0] pl_data,
    input wire logic pl_ready
);

    typedef struct packed {
        sxd_pkg::sxd_state_e state;
        logic sck_s1;
        logic sck_s2;
        logic sck_d;
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic mosi_s1;
        logic mosi_s2;
        logic [2:0] bitcnt;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic [7:0] cmd;
        logic [5:0] nbytes;
        logic pl_ok;
        logic feat;
        logic bank;
        logic [1:0] ack_cnt;
        logic miso;
        logic miso_oe;
        logic msb_first;
        logic pkt_done;
        logic pkt_noack;
        logic [2:0] pkt_pipe;
        logic [5:0] pkt_len;
        logic overflow;
        logic fifo_wr;
        logic [7:0] fifo_data;
    } sxd_regs_s;

    sxd_regs_s s;
    sxd_regs_s next_s;

    logic fifo_ready;
    logic in_frame;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic byte_done;
    logic [7:0] rx_byte;

    // Ack payload command with its pipe field
    function automatic logic is_ack_cmd(input logic [7:0] c);
        return c[7:3] == sxd_pkg::CMD_ACK_TOP;
    endfunction

    // Bank 1 low registers take the high byte first
    function automatic logic reg_msb_first(input logic bank,
                                           input logic [7:0] c);
        return bank && (c[4:0] <= sxd_pkg::BANK1_MSB_LAST_REG);
    endfunction

    // Edge and byte decode from synchronised pins
    assign in_frame = (s.state != sxd_pkg::ST_IDLE);
    assign sck_rise = in_frame && s.sck_s2 && !s.sck_d;
    assign sck_fall = in_frame && !s.sck_s2 && s.sck_d;
    assign cs_fall = !s.cs_s2 && s.cs_d;
    assign cs_rise = in_frame && s.cs_s2;
    assign byte_done = sck_rise && (s.bitcnt == sxd_pkg::BIT_LAST);
    assign rx_byte = {s.sh_in[6:0], s.mosi_s2};

    // Next-state logic of the whole decoder
    always_comb
    begin
        logic inc;
        logic dec;
        inc = 1'b0;
        dec = 1'b0;
        next_s = s;
        // Two-flop synchronisers on every pin
        next_s.sck_s1 = sck;
        next_s.sck_s2 = s.sck_s1;
        next_s.sck_d = s.sck_s2;
        next_s.cs_s1 = select_n_pin;
        next_s.cs_s2 = s.cs_s1;
        next_s.cs_d = s.cs_s2;
        next_s.mosi_s1 = mosi;
        next_s.mosi_s2 = s.mosi_s1;
        next_s.pkt_done = 1'b0;
        next_s.fifo_wr = 1'b0;
        dec = ack_sent && (s.ack_cnt != '0);
        if (cs_fall)
        begin
            // New command: status leads out, MSB first
            next_s.state = sxd_pkg::ST_CMD;
            next_s.bitcnt = '0;
            next_s.nbytes = '0;
            next_s.pl_ok = 1'b0;
            next_s.overflow = 1'b0;
            next_s.miso = status_in[7];
            next_s.sh_out = {status_in[6:0], 1'b0};
            next_s.miso_oe = 1'b1;
        end
        else if (cs_rise)
        begin
            // Frame end commits an accepted payload
            next_s.state = sxd_pkg::ST_IDLE;
            next_s.miso = 1'b0;
            next_s.miso_oe = 1'b0;
            if (s.state == sxd_pkg::ST_DATA && s.pl_ok && s.nbytes != '0)
            begin
                next_s.pkt_done = 1'b1;
                next_s.pkt_len = s.nbytes;
                next_s.pkt_pipe = s.cmd[2:0];
                next_s.pkt_noack =
                    (s.cmd == sxd_pkg::CMD_NOACK_TX);
                inc = (s.cmd != sxd_pkg::CMD_NOACK_TX);
            end
        end
        else if (in_frame)
        begin
            if (sck_rise)
            begin
                next_s.sh_in = rx_byte;
                next_s.bitcnt = s.bitcnt + 1'b1;
            end
            if (sck_fall)
            begin
                next_s.miso = s.sh_out[7];
                next_s.sh_out = {s.sh_out[6:0], 1'b0};
            end
            if (byte_done && s.state == sxd_pkg::ST_CMD)
            begin
                // Command byte decode
                next_s.cmd = rx_byte;
                next_s.state = sxd_pkg::ST_DATA;
                next_s.sh_out = '0;
                if (rx_byte == sxd_pkg::CMD_RX_WIDTH && s.feat)
                begin
                    next_s.sh_out = {2'b00, rx_width};
                end
                if (rx_byte[7:6] == sxd_pkg::CMD_REG_TOP)
                begin
                    next_s.msb_first =
                        reg_msb_first(s.bank, rx_byte);
                end
                // Payload writes need features and mode; ack writes also need pipe and room
                next_s.pl_ok = s.feat &&
                    ((is_ack_cmd(rx_byte) && rx_mode &&
                      rx_byte[2:0] <= sxd_pkg::PIPE_MAX &&
                      s.ack_cnt < sxd_pkg::ACK_PENDING_MAX) ||
                     (rx_byte == sxd_pkg::CMD_NOACK_TX && !rx_mode));
            end
            else if (byte_done)
            begin
                // Data byte handling
                next_s.sh_out = '0;
                if (s.nbytes < sxd_pkg::PAYLOAD_MAX)
                begin
                    next_s.nbytes = s.nbytes + 1'b1;
                end
                if (s.cmd == sxd_pkg::CMD_UNLOCK && s.nbytes == '0 &&
                    idle_power_state)
                begin
                    if (rx_byte == sxd_pkg::UNLOCK_FEATURES)
                    begin
                        next_s.feat = !s.feat;
                    end
                    else if (rx_byte == sxd_pkg::UNLOCK_BANK)
                    begin
                        next_s.bank = !s.bank;
                    end
                end
                if (s.pl_ok && s.nbytes < sxd_pkg::PAYLOAD_MAX)
                begin
                    if (fifo_ready)
                    begin
                        next_s.fifo_wr = 1'b1;
                        next_s.fifo_data = rx_byte;
                    end
                    else
                    begin
                        next_s.overflow = 1'b1;
                    end
                end
            end
        end
        next_s.ack_cnt = s.ack_cnt + 2'(inc) - 2'(dec);
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.state <= sxd_pkg::ST_IDLE;
            s.cs_s1 <= sxd_pkg::SELECT_IDLE;
            s.cs_s2 <= sxd_pkg::SELECT_IDLE;
            s.cs_d <= sxd_pkg::SELECT_IDLE;
            s.feat <= sxd_pkg::FEATURES_RESET;
            s.bank <= sxd_pkg::BANK_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Payload bytes to the transmit side
    sxd_fifo #(
        .WIDTH(sxd_pkg::FIFO_WIDTH),
        .DEPTH(sxd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_valid(s.fifo_wr),
        .in_data(s.fifo_data),
        .in_ready(fifo_ready),
        .out_valid(pl_valid),
        .out_data(pl_data),
        .out_ready(pl_ready)
    );

    // Outputs straight from state flops
    assign miso = s.miso;
    assign miso_oe = s.miso_oe;
    assign features_active = s.feat;
    assign bank_indicator_bit = s.bank;
    assign msb_byte_first = s.msb_first;
    assign pkt_done = s.pkt_done;
    assign pkt_no_auto_acknowledge = s.pkt_noack;
    assign ack_pipe_index = s.pkt_pipe;
    assign pkt_len = s.pkt_len;
    assign ack_pending = s.ack_cnt;
    assign overflow = s.overflow;

    // Checks on the decoder behaviour
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    logic unlock_byte;
    assign unlock_byte = byte_done && s.state == sxd_pkg::ST_DATA &&
        s.cmd == sxd_pkg::CMD_UNLOCK && s.nbytes == '0;

    a_feat_toggle: assert property (
        unlock_byte && idle_power_state &&
        rx_byte == sxd_pkg::UNLOCK_FEATURES
        |=> features_active != $past(features_active) &&
            $stable(bank_indicator_bit))
        else $error("features did not toggle on unlock");

    a_bank_toggle: assert property (
        unlock_byte && idle_power_state && rx_byte == sxd_pkg::UNLOCK_BANK
        |=> bank_indicator_bit != $past(bank_indicator_bit) &&
            $stable(features_active))
        else $error("bank did not toggle on unlock");

    a_unlock_other: assert property (
        unlock_byte && rx_byte != sxd_pkg::UNLOCK_FEATURES &&
        rx_byte != sxd_pkg::UNLOCK_BANK
        |=> $stable(features_active) && $stable(bank_indicator_bit))
        else $error("unknown unlock data changed state");

    a_unlock_gated: assert property (
        unlock_byte && !idle_power_state
        |=> $stable(features_active) && $stable(bank_indicator_bit))
        else $error("unlock honoured outside idle power state");

    a_width_answer: assert property (
        byte_done && s.state == sxd_pkg::ST_CMD &&
        rx_byte == sxd_pkg::CMD_RX_WIDTH
        |=> s.sh_out == ($past(s.feat) ? {2'b00, $past(rx_width)} : 8'h00))
        else $error("width answer wrong");

    a_pipe_range: assert property (
        pkt_done && !pkt_no_auto_acknowledge |-> ack_pipe_index <= sxd_pkg::PIPE_MAX)
        else $error("ack payload on invalid pipe");

    a_ack_limit: assert property (
        ack_pending == sxd_pkg::ACK_PENDING_MAX |=> ack_pending != 2'h0)
        else $error("too many ack payloads pending");

    a_len_range: assert property (
        pkt_done |-> pkt_len != '0 && pkt_len <= sxd_pkg::PAYLOAD_MAX)
        else $error("payload length out of range");

    a_nop_still: assert property (
        s.state == sxd_pkg::ST_DATA && s.cmd == sxd_pkg::CMD_NOP
        |=> !s.fifo_wr && !pkt_done && $stable(features_active))
        else $error("no-op changed state");

    a_byte_order: assert property (
        byte_done && s.state == sxd_pkg::ST_CMD &&
        rx_byte[7:6] == sxd_pkg::CMD_REG_TOP
        |=> msb_byte_first == ($past(s.bank) &&
            $past(rx_byte[4:0]) <= sxd_pkg::BANK1_MSB_LAST_REG))
        else $error("byte order flag wrong");

    a_status_lead: assert property (
        cs_fall |=> miso == $past(status_in[7]) && miso_oe)
        else $error("status bit 7 not leading");

    a_cmd_msb: assert property (
        byte_done && s.state == sxd_pkg::ST_CMD
        |=> s.cmd == {$past(s.sh_in[6:0]), $past(s.mosi_s2)})
        else $error("command byte not captured MSB first");

    c_feat_on: cover property (!features_active ##1 features_active);
    c_bank_on: cover property (!bank_indicator_bit ##1 bank_indicator_bit);
    c_ack_pkt: cover property (pkt_done && !pkt_no_auto_acknowledge);
    c_noack_pkt: cover property (pkt_done && pkt_no_auto_acknowledge);

endmodule

`default_nettype wire

// ### tb/sxd_master_model.sv
// Serial master model: drives select, clock and data in whole frames.
// Assumes mode 0, a 64 ns serial clock and a bench that fills tx.
`default_nettype none

module sxd_master_model (
    output var logic sck,
    output var logic select_n_pin,
    output var logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] tx [0:39];
    logic [7:0] rx [0:39];

    // Idle pins
    initial
    begin
        sck = 1'b0;
        select_n_pin = 1'b1;
        mosi = 1'b0;
    end

    // One frame of n bytes, command byte first, bits MSB first
    task automatic frame(input int n);
        select_n_pin = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            for (int b = 7; b >= 0; b--)
            begin
                mosi = tx[i][b];
                #32;
                sck = 1'b1;
                rx[i][b] = miso;
                #32;
                sck = 1'b0;
            end
        end
        mosi = ~mosi; // Inverted line stops showing last bit
        #32;
        select_n_pin = 1'b1;
        #100; // Select high well over minimum
    endtask
endmodule

`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench of the extended serial command decoder.
// Assumes the master model drives the serial pins; 200 MHz mclk.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk, rst_n, idle_power_state, rx_mode, ack_sent, pl_ready;
    logic [7:0] status_in;
    logic [5:0] rx_width;
    wire logic sck, select_n_pin, mosi;
    logic miso, miso_oe, features_active, bank_indicator_bit;
    logic msb_byte_first, pkt_done, pkt_no_auto_acknowledge, overflow;
    logic pl_valid;
    logic [2:0] ack_pipe_index;
    logic [5:0] pkt_len;
    logic [1:0] ack_pending;
    logic [7:0] pl_data;
    logic [31:0] seed = 32'hE4E3;
    logic [15:0] exp_pl [$];
    logic [15:0] exp_pkt [$];
    logic ign;
    int n_mismatch = 0;
    int compares = 0;

    sxd_master_model master (.sck(sck), .select_n_pin(select_n_pin),
        .mosi(mosi), .miso(miso));

    sxd_decoder uut (.mclk(mclk), .rst_n(rst_n), .sck(sck),
        .select_n_pin(select_n_pin), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe), .status_in(status_in), .rx_width(rx_width),
        .idle_power_state(idle_power_state), .rx_mode(rx_mode),
        .ack_sent(ack_sent), .features_active(features_active),
        .bank_indicator_bit(bank_indicator_bit),
        .msb_byte_first(msb_byte_first), .pkt_done(pkt_done),
        .pkt_no_auto_acknowledge(pkt_no_auto_acknowledge), .ack_pipe_index(ack_pipe_index),
        .pkt_len(pkt_len), .ack_pending(ack_pending), .overflow(overflow),
        .pl_valid(pl_valid), .pl_data(pl_data), .pl_ready(pl_ready));

    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Frame start aligned just after an edge
    task automatic go(input int n);
        @(posedge mclk);
        #1;
        master.frame(n);
        @(posedge mclk);
        #1;
    endtask

    task automatic unlock(input logic [7:0] d);
        master.tx[0] = sxd_pkg::CMD_UNLOCK;
        master.tx[1] = d;
        go(2);
    endtask

    // Payload frame; ok notes the packet, lim caps the bytes kept
    task automatic payload(input logic [7:0] c, input int n,
                           input logic ok, input int lim);
        master.tx[0] = c;
        ign = ~ok;
        for (int i = 1; i <= n; i++)
        begin
            master.tx[i] = rnd();
            if (ok && i <= lim)
                exp_pl.push_back({8'h00, master.tx[i]});
        end
        if (ok)
            exp_pkt.push_back({6'h00, c == sxd_pkg::CMD_NOACK_TX,
                c[2:0], n[5:0]});
        go(n + 1);
        repeat (10) @(posedge mclk);
        #1;
        ign = 1'b0;
    endtask

    task automatic pulse_sent();
        @(posedge mclk);
        #1 ack_sent = 1'b1;
        @(posedge mclk);
        #1 ack_sent = 1'b0;
    endtask

    // Result watcher: oldest note against each result shown
    always @(posedge mclk)
    begin
        if (pl_valid === 1'b1 && pl_ready === 1'b1 && !ign)
            chk({8'h00, pl_data}, exp_pl.size() ? exp_pl.pop_front()
                : 16'hFFFF);
        if (pkt_done === 1'b1)
            chk({6'h00, pkt_no_auto_acknowledge, ack_pipe_index, pkt_len},
                exp_pkt.size() ? exp_pkt.pop_front() : 16'hFFFF);
    end

    // Output enable must stand at every serial clock rise
    always @(posedge sck)
    begin
        chk(miso_oe, 1'b1);
    end

    // Watchdog
    initial
    begin
        #400us;
        n_mismatch++;
        conclude();
    end

    // Main sequence
    initial
    begin
        logic [7:0] st;
        logic [7:0] regs [4];
        logic exp_msb [4];
        regs = '{8'h25, 8'h08, 8'h09, 8'h2E};
        exp_msb = '{1'b1, 1'b1, 1'b0, 1'b0};
        rst_n = 1'b0;
        status_in = 8'h00;
        rx_width = 6'h00;
        idle_power_state = 1'b1;
        rx_mode = 1'b1;
        ack_sent = 1'b0;
        pl_ready = 1'b1;
        ign = 1'b0;
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        chk(features_active, 1'b0);
        chk(bank_indicator_bit, 1'b0);
        st = rnd();
        status_in = st;
        rx_width = 6'h11;
        master.tx[0] = sxd_pkg::CMD_RX_WIDTH;
        master.tx[1] = rnd();
        go(2);
        chk(master.rx[0], st);
        chk(master.rx[1], 8'h00);
        payload(8'hA9, 2, 1'b0, 0);
        chk(ack_pending, 2'h0);
        idle_power_state = 1'b0;
        unlock(sxd_pkg::UNLOCK_FEATURES);
        chk(features_active, 1'b0);
        idle_power_state = 1'b1;
        unlock(sxd_pkg::UNLOCK_FEATURES);
        chk(features_active, 1'b1);
        unlock(8'h11);
        chk({features_active, bank_indicator_bit}, 2'b10);
        unlock(sxd_pkg::UNLOCK_BANK);
        chk(bank_indicator_bit, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            master.tx[0] = regs[i];
            master.tx[1] = 8'h00;
            go(2);
            chk(msb_byte_first, exp_msb[i]);
        end
        unlock(sxd_pkg::UNLOCK_BANK);
        master.tx[0] = 8'h05;
        go(2);
        chk({bank_indicator_bit, msb_byte_first}, 2'b00);
        st = rnd();
        status_in = st;
        master.tx[0] = sxd_pkg::CMD_NOP;
        go(1);
        chk(master.rx[0], st);
        chk({features_active, bank_indicator_bit, ack_pending, miso_oe},
            5'b10000);
        rx_width = rnd() % 32 + 1;
        master.tx[0] = sxd_pkg::CMD_RX_WIDTH;
        go(2);
        chk(master.rx[1], {2'b00, rx_width});
        payload(8'hAE, 2, 1'b0, 0);
        chk(ack_pending, 2'h0);
        for (int p = 0; p < 6; p++)
        begin
            if (p == 3)
            begin
                payload(8'hAB, 1, 1'b0, 0);
                chk(ack_pending, 2'h3);
            end
            if (p >= 3)
                pulse_sent();
            payload(8'hA8 | p, p == 5 ? 32 : 1 + p * 6, 1'b1, 40);
            chk(ack_pending, p < 3 ? p + 1 : 3);
        end
        payload(sxd_pkg::CMD_NOACK_TX, 3, 1'b0, 0);
        rx_mode = 1'b0;
        payload(8'hA8, 3, 1'b0, 0);
        payload(sxd_pkg::CMD_NOACK_TX, 4, 1'b1, 40);
        pl_ready = 1'b0;
        payload(sxd_pkg::CMD_NOACK_TX, 17, 1'b1, 16);
        chk(overflow, 1'b1);
        pl_ready = 1'b1;
        repeat (50) @(posedge mclk);
        master.tx[0] = sxd_pkg::CMD_NOP;
        go(1);
        chk(overflow, 1'b0);
        unlock(sxd_pkg::UNLOCK_FEATURES);
        chk(features_active, 1'b0);
        repeat (20) @(posedge mclk);
        chk(exp_pl.size() + exp_pkt.size(), 16'h0000);
        conclude();
    end
endmodule

`default_nettype wire
